// ===== core/autoreload_pwm_timer.sv
// Twelve-bit auto-reload timer with four PWM channels, compare and capture.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module autoreload_pwm_timer #(
   parameter int N_CH = 4
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Counter clock ticks.
   input wire autoreload_pwm_pkg::tick_in_t ticks,
   // Pins.
   input wire logic stop_in_n,
   input wire logic capture_input,
   output logic [3:0] pwm_out,
   // Interrupt request lines.
   output logic cmp_cap_irq,
   output logic ovf_irq
);
   import autoreload_pwm_pkg::*;

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [11:0] up_counter_reg, reload_register_reg, capture_value_reg;
   logic [11:0] duty_shadow_reg [N_CH];
   logic [11:0] duty_active_reg [N_CH];
   logic [N_CH-1:0] output_enable_control_reg, pol_reg, pol_act_reg;
   logic [N_CH-1:0] compare_flag_reg, gpio_reg, pwm_raw_reg;
   logic transfer_sync_reg, stop_pin_enable_reg, stop_active_reg;
   logic [3:0] stop_pattern_reg;
   logic overflow_flag_reg, overflow_irq_enable_reg, compare_irq_enable_reg;
   logic capture_flag_reg, capture_irq_enable_reg;
   logic [1:0] counter_clock_select_reg;
   logic [3:0] mode_reg;
   logic [4:0] slow_div_reg;
   logic stop_s1_reg, stop_s2_reg, cap_s1_reg, cap_s2_reg, cap_d_reg;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   logic wr, rd;
   logic [3:0] ch_idx;
   logic in_csr, in_duty, mapped;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign ch_idx = 4'((paddr - ADDR_CH_CSR) >> CH_STRIDE_SHIFT);
   assign in_csr = paddr >= ADDR_CH_CSR && paddr < ADDR_DUTY
                   && paddr[1:0] == 2'h0;
   assign in_duty = paddr >= ADDR_DUTY && paddr < ADDR_GPIO
                    && paddr[1:0] == 2'h0;
   logic [3:0] duty_idx;
   assign duty_idx = 4'((paddr - ADDR_DUTY) >> CH_STRIDE_SHIFT);
   assign mapped = in_csr || in_duty || paddr == ADDR_STATUS
      || paddr == ADDR_COUNTER || paddr == ADDR_RELOAD
      || paddr == ADDR_OUT_EN || paddr == ADDR_TRANSFER
      || paddr == ADDR_STOP || paddr == ADDR_CAPTURE
      || paddr == ADDR_MODE || paddr == ADDR_GPIO;

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   // Stop uses only the second stage; capture compares the second stage with a third.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_s1_reg <= 1'b1;
         stop_s2_reg <= 1'b1;
         cap_s1_reg <= 1'b0;
         cap_s2_reg <= 1'b0;
         cap_d_reg <= 1'b0;
      end else begin
         stop_s1_reg <= stop_in_n;
         stop_s2_reg <= stop_s1_reg;
         cap_s1_reg <= capture_input;
         cap_s2_reg <= cap_s1_reg;
         cap_d_reg <= cap_s2_reg;
      end
   end

   // -----------------------------------------------------------------
   // Counter clock selection and low power modes
   // -----------------------------------------------------------------
   logic sel_tick, tick, halted, ovf_evt, shutdown;
   always_comb begin
      unique case (clk_sel_t'(counter_clock_select_reg))
         CK_OFF: sel_tick = 1'b0;
         CK_LOW: sel_tick = ticks.low_tick;
         CK_CPU: sel_tick = ticks.cpu_tick;
         CK_FAST: sel_tick = ticks.fast_tick;
      endcase
   end
   // Wait mode bit is stored but deliberately has no effect.
   assign halted = mode_reg[MODE_HALT]
      || (mode_reg[MODE_AHALT] && !(counter_clock_select_reg == CK_LOW
          && overflow_irq_enable_reg));
   // Slow mode keeps one tick in every 32 of the selected clock.
   assign tick = sel_tick && !halted
      && (!mode_reg[MODE_SLOW] || slow_div_reg == 5'(SLOW_DIV - 1));
   assign ovf_evt = tick && up_counter_reg == CNT_MAX;
   assign shutdown = stop_active_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_div_reg <= 5'h00;
      end else if (sel_tick && !halted && mode_reg[MODE_SLOW]) begin
         slow_div_reg <= slow_div_reg + 5'h01;
      end
   end

   // -----------------------------------------------------------------
   // Up counter
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_counter_reg <= CNT_RESET;
      end else if (shutdown) begin
         up_counter_reg <= CNT_RESET;
      end else if (ovf_evt) begin
         up_counter_reg <= reload_register_reg;
      end else if (tick) begin
         up_counter_reg <= up_counter_reg + 12'h001;
      end
   end

   // -----------------------------------------------------------------
   // Channels: duty, polarity, compare and waveform
   // -----------------------------------------------------------------
   logic rd_csr_hit;
   assign rd_csr_hit = rd && in_csr;
   generate
      for (genvar c = 0; c < N_CH; c++) begin : g_ch
         logic match;
         assign match = tick && !ovf_evt
                        && up_counter_reg + 12'h001 == duty_active_reg[c];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               duty_shadow_reg[c] <= CNT_RESET;
               duty_active_reg[c] <= CNT_RESET;
            end else if (shutdown) begin
               duty_shadow_reg[c] <= CNT_RESET;
               duty_active_reg[c] <= CNT_RESET;
            end else begin
               if (wr && in_duty && duty_idx == 4'(c))
                  duty_shadow_reg[c] <= pwdata[11:0];
               if (ovf_evt)
                  duty_active_reg[c] <= duty_shadow_reg[c];
            end
         end
         // Raw wave: high at overflow, low once the counter hits duty.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pwm_raw_reg[c] <= 1'b0;
            end else if (shutdown) begin
               pwm_raw_reg[c] <= 1'b0;
            end else if (ovf_evt) begin
               pwm_raw_reg[c] <= 1'b1;
            end else if (match) begin
               pwm_raw_reg[c] <= 1'b0;
            end
         end
         // Compare flag: set wins over the clearing read.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               compare_flag_reg[c] <= 1'b0;
            end else if (match && duty_active_reg[c] != CNT_RESET) begin
               compare_flag_reg[c] <= 1'b1;
            end else if (rd_csr_hit && ch_idx == 4'(c)) begin
               compare_flag_reg[c] <= 1'b0;
            end
         end
         // Effective polarity follows the bit at once or at overflow.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pol_act_reg[c] <= 1'b0;
            end else if (!transfer_sync_reg || ovf_evt) begin
               pol_act_reg[c] <= pol_reg[c];
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // Control registers written by software
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_register_reg <= CNT_RESET;
         output_enable_control_reg <= '0;
      end else if (shutdown) begin
         reload_register_reg <= CNT_RESET;
         output_enable_control_reg <= '0;
      end else if (wr && paddr == ADDR_RELOAD) begin
         reload_register_reg <= pwdata[11:0];
      end else if (wr && paddr == ADDR_OUT_EN) begin
         output_enable_control_reg <= pwdata[N_CH-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol_reg <= '0;
         transfer_sync_reg <= 1'b1;
         gpio_reg <= '0;
         mode_reg <= 4'h0;
      end else if (wr) begin
         if (in_csr && ch_idx < 4'(N_CH))
            pol_reg[ch_idx[1:0]] <= pwdata[CSR_POL];
         if (paddr == ADDR_TRANSFER)
            transfer_sync_reg <= pwdata[0];
         if (paddr == ADDR_GPIO)
            gpio_reg <= pwdata[N_CH-1:0];
         if (paddr == ADDR_MODE)
            mode_reg <= pwdata[3:0];
      end
   end

   // Status register: overflow flag set wins over its clearing read.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag_reg <= 1'b0;
         overflow_irq_enable_reg <= 1'b0;
         compare_irq_enable_reg <= 1'b0;
         capture_irq_enable_reg <= 1'b0;
         counter_clock_select_reg <= CK_OFF;
      end else begin
         if (ovf_evt)
            overflow_flag_reg <= 1'b1;
         else if (rd && paddr == ADDR_STATUS)
            overflow_flag_reg <= 1'b0;
         if (wr && paddr == ADDR_STATUS) begin
            compare_irq_enable_reg <= pwdata[ST_CMP_IE];
            overflow_irq_enable_reg <= pwdata[ST_OVF_IE];
            counter_clock_select_reg <= pwdata[ST_CK_LO +: 2];
            capture_irq_enable_reg <= pwdata[ST_CAP_IE];
         end
      end
   end

   // -----------------------------------------------------------------
   // Emergency stop
   // -----------------------------------------------------------------
   // The pin level is latched; only software clears the active bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_active_reg <= 1'b0;
         stop_pin_enable_reg <= 1'b0;
         stop_pattern_reg <= 4'h0;
      end else begin
         if (wr && paddr == ADDR_STOP) begin
            stop_pin_enable_reg <= pwdata[STOP_PEN];
            stop_pattern_reg <= pwdata[STOP_PAT_LO +: 4];
         end
         if (stop_pin_enable_reg && !stop_s2_reg)
            stop_active_reg <= 1'b1;
         else if (wr && paddr == ADDR_STOP)
            stop_active_reg <= pwdata[STOP_ACT];
      end
   end

   // -----------------------------------------------------------------
   // Input capture
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_flag_reg <= 1'b0;
         capture_value_reg <= CNT_RESET;
      end else if (!capture_flag_reg && cap_s2_reg != cap_d_reg) begin
         capture_flag_reg <= 1'b1;
         capture_value_reg <= up_counter_reg;
      end else if (rd && paddr == ADDR_CAPTURE && capture_flag_reg) begin
         capture_flag_reg <= 1'b0;
      end
      // An edge while the flag stands falls through untouched
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Pattern is applied after the inverter so polarity never masks it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_out <= 4'h0;
         cmp_cap_irq <= 1'b0;
         ovf_irq <= 1'b0;
      end else begin
         for (int i = 0; i < N_CH; i++) begin
            if (shutdown)
               pwm_out[i] <= stop_pattern_reg[i];
            else if (output_enable_control_reg[i])
               pwm_out[i] <= pwm_raw_reg[i] ^ pol_act_reg[i];
            else
               pwm_out[i] <= gpio_reg[i];
         end
         cmp_cap_irq <= (compare_irq_enable_reg && |compare_flag_reg)
                        || (capture_irq_enable_reg && capture_flag_reg);
         ovf_irq <= overflow_irq_enable_reg && overflow_flag_reg;
      end
   end

   // Read data and answer, registered into the access phase.
   logic [31:0] rdata;
   always_comb begin
      rdata = RD_ZERO;
      if (paddr == ADDR_STATUS) begin
         rdata[ST_CMP_IE] = compare_irq_enable_reg;
         rdata[ST_OVF_IE] = overflow_irq_enable_reg;
         rdata[ST_OVF] = overflow_flag_reg;
         rdata[ST_CK_LO +: 2] = counter_clock_select_reg;
         rdata[ST_CAP_IE] = capture_irq_enable_reg;
         rdata[ST_CAP_F] = capture_flag_reg;
      end else if (paddr == ADDR_COUNTER) rdata[11:0] = up_counter_reg;
      else if (paddr == ADDR_RELOAD) rdata[11:0] = reload_register_reg;
      else if (paddr == ADDR_OUT_EN) rdata[N_CH-1:0] = output_enable_control_reg;
      else if (paddr == ADDR_TRANSFER) rdata[0] = transfer_sync_reg;
      else if (paddr == ADDR_STOP) begin
         rdata[STOP_PAT_LO +: 4] = stop_pattern_reg;
         rdata[STOP_PEN] = stop_pin_enable_reg;
         rdata[STOP_ACT] = stop_active_reg;
      end else if (paddr == ADDR_CAPTURE) rdata[11:0] = capture_value_reg;
      else if (paddr == ADDR_MODE) rdata[3:0] = mode_reg;
      else if (paddr == ADDR_GPIO) rdata[N_CH-1:0] = gpio_reg;
      else if (in_csr && ch_idx < 4'(N_CH)) begin
         rdata[CSR_COMPARE_FLAG] = compare_flag_reg[ch_idx[1:0]];
         rdata[CSR_POL] = pol_reg[ch_idx[1:0]];
      end else if (in_duty && duty_idx < 4'(N_CH))
         rdata[11:0] = duty_shadow_reg[duty_idx[1:0]];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= RD_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (psel && !penable && !pwrite)
            prdata <= rdata;
      end
   end
endmodule : autoreload_pwm_timer
`default_nettype wire

// ===== include/autoreload_pwm_pkg.sv
// Register map, fields and shared types of the PWM timer.
//
// What this block does
// - Channels share one period; counter reloads after overflow.
// - Reset starts the counter at zero.
// - Overflow loads preloaded duties and sets outputs high.
// - Counter at active duty drives channel low until overflow.
// - Each channel output has its own enable bit.
// - Polarity bit inverts output; sync bit delays change to overflow.
// - Duty resolution is one step over 4096 minus reload.
// - Counter at duty sets compare flag; interrupt if enabled.
// - Zero duty gives no compare events.
// - With pin enabled, low stop input sets stop-active.
// - Writing one to stop-active activates shutdown.
// - While stopping, stop pattern drives pins after the inverter.
// - Shutdown clears counter, reload, duties, shadows and enables.
// - Clearing stop-active hands pins to port values.
// - Stop-active bit stays set until software clears it.
// - Capture edge copies counter, sets flag, interrupt if enabled.
// - Reading capture value with flag set clears it.
// - Edges are ignored while capture flag is set.
// - Slow divides by 32; wait has no effect; halt stops.
// - Active-halt stops unless low-speed clock and overflow irq enabled.
// - Compare and capture share an irq; overflow has its own.
// - Two-bit clock select: off, low-speed, cpu, fast clock.
// - Overflow flag set on wrap to reload, cleared by status read.
// - Compare flag cleared by reading its channel status register.
package autoreload_pwm_pkg;
   // -----------------------------------------------------------------
   // Register byte addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_COUNTER = 8'h04;
   localparam logic [7:0] ADDR_RELOAD = 8'h08;
   localparam logic [7:0] ADDR_OUT_EN = 8'h0c;
   localparam logic [7:0] ADDR_TRANSFER = 8'h10;
   localparam logic [7:0] ADDR_STOP = 8'h14;
   localparam logic [7:0] ADDR_CAPTURE = 8'h18;
   localparam logic [7:0] ADDR_MODE = 8'h1c;
   localparam logic [7:0] ADDR_CH_CSR = 8'h20;
   localparam logic [7:0] ADDR_DUTY = 8'h30;
   localparam logic [7:0] ADDR_GPIO = 8'h40;
   localparam int CH_STRIDE_SHIFT = 2;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int ST_CMP_IE = 0;
   localparam int ST_OVF_IE = 1;
   localparam int ST_OVF = 2;
   localparam int ST_CK_LO = 3;
   localparam int ST_CAP_IE = 5;
   localparam int ST_CAP_F = 6;
   localparam int CSR_COMPARE_FLAG = 0;
   localparam int CSR_POL = 1;
   localparam int STOP_PAT_LO = 0;
   localparam int STOP_PEN = 4;
   localparam int STOP_ACT = 5;
   localparam int MODE_SLOW = 0;
   localparam int MODE_HALT = 1;
   localparam int MODE_AHALT = 2;
   localparam int MODE_WAIT = 3;
   // -----------------------------------------------------------------
   // Constants
   // -----------------------------------------------------------------
   localparam int CNT_W = 12;
   localparam logic [11:0] CNT_MAX = 12'hfff;
   localparam logic [11:0] CNT_RESET = 12'h000;
   localparam int SLOW_DIV = 32;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {
      CK_OFF = 2'b00,
      CK_LOW = 2'b01,
      CK_CPU = 2'b10,
      CK_FAST = 2'b11
   } clk_sel_t;
   // Ticks from the surrounding clock generator.
   typedef struct packed {
      logic low_tick;
      logic cpu_tick;
      logic fast_tick;
   } tick_in_t;
endpackage : autoreload_pwm_pkg

// ===== test/converter_model.sv
// Converter model: times the PWM pins, drives fault and sense.
`timescale 1ns/1ps
`default_nettype none
module converter_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Commands from the bench.
   input wire logic trip,
   input wire logic sense,
   // Pins.
   input wire logic [3:0] pwm_out,
   output logic stop_in_n,
   output logic capture_input,
   // Last measured high time and period of each channel.
   output logic [3:0][11:0] high_len,
   output logic [3:0][11:0] per_len
);
   logic [3:0][11:0] hcnt_reg;
   logic [3:0][11:0] pcnt_reg;
   logic [3:0] last_reg;
   // Fault line is low only while the bench trips it.
   assign stop_in_n = !trip;
   assign capture_input = sense;
   // Period runs rise to rise; high time ends at the fall.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hcnt_reg <= '0;
         pcnt_reg <= '0;
         last_reg <= 4'h0;
         high_len <= '0;
         per_len <= '0;
      end else begin
         last_reg <= pwm_out;
         for (int c = 0; c < 4; c++) begin
            pcnt_reg[c] <= pcnt_reg[c] + 12'h1;
            hcnt_reg[c] <= pwm_out[c] ? hcnt_reg[c] + 12'h1 : 12'h0;
            if (pwm_out[c] && !last_reg[c]) begin
               per_len[c] <= pcnt_reg[c];
               pcnt_reg[c] <= 12'h1;
            end
            if (!pwm_out[c] && last_reg[c]) begin
               high_len[c] <= hcnt_reg[c];
            end
         end
      end
   end
endmodule : converter_model
`default_nettype wire

// ===== test/pwm_timer_asserts.sv
// Checker on the PWM timer's bus, pins and interrupts.
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_asserts
   import autoreload_pwm_pkg::*;
#(
   parameter int N_CH = 4
) (
   // Clock, reset and bus.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and interrupts.
   input wire tick_in_t ticks,
   input wire logic stop_in_n,
   input wire logic [3:0] pwm_out,
   input wire logic cmp_cap_irq,
   input wire logic ovf_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // -----------------------------------------------------------------
   // Quiet time
   // -----------------------------------------------------------------
   // Pins move only soon after a tick, an access or a stop edge.
   logic [3:0] quiet_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_reg <= 4'h0;
      end else if (|ticks || pready || $changed(stop_in_n)) begin
         quiet_reg <= 4'h0;
      end else if (quiet_reg != 4'hf) begin
         quiet_reg <= quiet_reg + 4'h1;
      end
   end
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   ready_single_a: assert property (pready |=> !pready)
      else $error("answer held too long");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("answer outside access");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without answer");
   unmapped_err_a: assert property (pready && paddr > ADDR_GPIO |-> pslverr)
      else $error("unmapped access accepted");
   err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == RD_ZERO)
      else $error("refused read not zero");
   value_width_a: assert property (
      pready && !pwrite && (paddr == ADDR_COUNTER || paddr == ADDR_CAPTURE)
      |-> prdata[31:12] == 20'h0) else $error("value wider than 12 bits");
   pin_cause_a: assert property ($changed(pwm_out) |-> quiet_reg < 4'h6)
      else $error("pin moved without cause");
   ovf_rise_a: assert property ($rose(ovf_irq) |->
      $past(|ticks, 2) || $past(pready, 2) || $past(pready, 3))
      else $error("overflow irq without cause");
   ovf_fall_a: assert property ($fell(ovf_irq) |->
      $past(pready, 1) || $past(pready, 2) || $past(pready, 3))
      else $error("overflow irq fell unread");
   cmp_fall_a: assert property ($fell(cmp_cap_irq) |->
      $past(pready, 1) || $past(pready, 2) || $past(pready, 3))
      else $error("event irq fell unread");
endmodule : pwm_timer_asserts
bind autoreload_pwm_timer pwm_timer_asserts #(.N_CH(N_CH)) u_pwm_timer_asserts (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .ticks(ticks), .stop_in_n(stop_in_n),
   .pwm_out(pwm_out), .cmp_cap_irq(cmp_cap_irq), .ovf_irq(ovf_irq));
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the auto-reload PWM timer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import autoreload_pwm_pkg::*;
   typedef struct {
      logic w; logic [7:0] a; logic [31:0] d, x; logic e;
   } row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic stop_in_n, capture_input, cmp_cap_irq, ovf_irq, trip, sense;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, cv, cv2;
   logic [3:0] pwm_out;
   logic [2:0] cyc;
   logic [3:0][11:0] high_len, per_len;
   tick_in_t ticks;
   int n_errors = 0;
   int n_checks = 0;
   row_t rows [14] = '{'{1'h0, ADDR_TRANSFER, 32'h0, 32'h1, 1'h0},
      '{1'h0, ADDR_COUNTER, 32'h0, 32'h0, 1'h0},
      '{1'h0, ADDR_STOP, 32'h0, 32'h0, 1'h0},
      '{1'h0, ADDR_CAPTURE, 32'h0, 32'h0, 1'h0},
      '{1'h1, 8'h44, 32'hffff_ffff, 32'h0, 1'h1},
      '{1'h0, 8'h44, 32'h0, 32'h0, 1'h1},
      '{1'h1, ADDR_RELOAD, 32'hff0, 32'h0, 1'h0},
      '{1'h0, ADDR_RELOAD, 32'h0, 32'hff0, 1'h0},
      '{1'h1, 8'h30, 32'hff4, 32'h0, 1'h0},
      '{1'h1, 8'h34, 32'hff8, 32'h0, 1'h0},
      '{1'h1, 8'h38, 32'hffc, 32'h0, 1'h0},
      '{1'h1, 8'h3c, 32'h0, 32'h0, 1'h0},
      '{1'h1, ADDR_OUT_EN, 32'hf, 32'h0, 1'h0},
      '{1'h1, ADDR_STATUS, 32'h12, 32'h0, 1'h0}};
   logic [7:0] zaddr [4] = '{ADDR_RELOAD, ADDR_OUT_EN, ADDR_COUNTER, ADDR_DUTY};
   autoreload_pwm_timer u_autoreload_pwm_timer (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ticks(ticks), .stop_in_n(stop_in_n), .capture_input(capture_input),
      .pwm_out(pwm_out), .cmp_cap_irq(cmp_cap_irq), .ovf_irq(ovf_irq));
   converter_model u_converter_model (.pclk(pclk), .presetn(presetn),
      .trip(trip), .sense(sense), .pwm_out(pwm_out), .stop_in_n(stop_in_n),
      .capture_input(capture_input), .high_len(high_len), .per_len(per_len));
   // -----------------------------------------------------------------
   // Clock and counter ticks
   // -----------------------------------------------------------------
   initial begin
      pclk = 1'h0;
      forever #10 pclk = ~pclk;
   end
   // The cpu tick fires every cycle: one count per clock.
   always @(posedge pclk) begin
      cyc <= cyc + 3'h1;
      ticks <= tick_in_t'({cyc[2], 1'h1, cyc[0]});
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d, rd, err);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, x);
      apb(1'h0, a, 32'h0, rd, err);
      chk(rd & m, x);
   endtask : rchk
   task automatic edge_in;
      sense <= ~sense;
      repeat (8) @(posedge pclk);
   endtask : edge_in
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   // A hang counts as a mismatch and ends the run.
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      print_verdict;
   end
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, trip, sense} = 6'h0;
      {paddr, pwdata, cyc, ticks} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      chk({28'h0, pwm_out}, 32'h0);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, rd, err);
         chk({31'h0, err}, {31'h0, rows[i].e});
         if (!rows[i].w) chk(rd, rows[i].x);
      end
      // First overflow needs a full run from zero.
      repeat (4200) @(posedge pclk);
      for (int c = 0; c < 3; c++) begin
         chk({20'h0, per_len[c]}, 32'h10);
         chk({20'h0, high_len[c]}, 32'(4 * (c + 1)));
      end
      chk({31'h0, ovf_irq}, 32'h1);
      rchk(ADDR_STATUS, 32'h4, 32'h4);
      rchk(ADDR_CH_CSR, 32'h1, 32'h1);
      rchk(ADDR_CH_CSR + 8'hc, 32'h1, 32'h0);
      wr(ADDR_CH_CSR, 32'h2);
      repeat (60) @(posedge pclk);
      chk({20'h0, high_len[0]}, 32'hc);
      // Capture with the counter stopped, so the value is known.
      wr(ADDR_STATUS, 32'h20);
      apb(1'h0, ADDR_COUNTER, 32'h0, cv, err);
      edge_in;
      rchk(ADDR_STATUS, 32'h40, 32'h40);
      chk({31'h0, cmp_cap_irq}, 32'h1);
      wr(ADDR_STATUS, 32'h30);
      repeat (5) @(posedge pclk);
      edge_in;
      wr(ADDR_STATUS, 32'h20);
      apb(1'h0, ADDR_COUNTER, 32'h0, cv2, err);
      rchk(ADDR_CAPTURE, 32'hffff_ffff, cv);
      rchk(ADDR_STATUS, 32'h40, 32'h0);
      edge_in;
      rchk(ADDR_CAPTURE, 32'hffff_ffff, cv2);
      // Emergency stop from the pin, then from software.
      wr(ADDR_STOP, 32'h15);
      trip <= 1'h1;
      repeat (4) @(posedge pclk);
      trip <= 1'h0;
      repeat (4) @(posedge pclk);
      chk({28'h0, pwm_out}, 32'h5);
      rchk(ADDR_STOP, 32'h20, 32'h20);
      foreach (zaddr[i]) rchk(zaddr[i], 32'hfff, 32'h0);
      wr(ADDR_GPIO, 32'ha);
      wr(ADDR_STOP, 32'h0);
      repeat (3) @(posedge pclk);
      chk({28'h0, pwm_out}, 32'ha);
      wr(ADDR_STOP, 32'h23);
      repeat (3) @(posedge pclk);
      chk({28'h0, pwm_out}, 32'h3);
      // Halt and active-halt freeze the counter.
      wr(ADDR_STOP, 32'h0);
      wr(ADDR_STATUS, 32'h10);
      for (int m = 2; m <= 4; m += 2) begin
         wr(ADDR_MODE, 32'(m));
         apb(1'h0, ADDR_COUNTER, 32'h0, cv, err);
         repeat (10) @(posedge pclk);
         rchk(ADDR_COUNTER, 32'hfff, cv);
      end
      print_verdict;
   end
endmodule : testbench
`default_nettype wire
